// file: hdl/frame_pkg.sv
// Package of framing constants for the motion command frame handler
package frame_pkg;
	// Frame geometry
	localparam int CORE_BYTES = 7;
	localparam int SERIAL_BYTES = 9;
	localparam logic [3:0] SER_LAST = 4'h8;
	localparam logic [3:0] CAN_LAST = 4'h6;
	// Serial frame positions
	localparam logic [3:0] POS_ADDR = 4'h0;
	localparam logic [3:0] POS_CMD = 4'h1;
	localparam logic [3:0] POS_TYPE = 4'h2;
	localparam logic [3:0] POS_BANK = 4'h3;
	localparam logic [3:0] POS_VAL0 = 4'h4;
	localparam logic [3:0] POS_VAL1 = 4'h5;
	localparam logic [3:0] POS_VAL2 = 4'h6;
	localparam logic [3:0] POS_VAL3 = 4'h7;
	// Last count of a CAN reply: status, command, four value bytes
	localparam logic [3:0] CAN_TX_LAST = 4'h5;
	// Status codes
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_STORED = 8'h65;
	localparam logic [7:0] ST_BAD_SUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_VAL = 8'h04;
	localparam logic [7:0] ST_LOCKED = 8'h05;
	localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
	// Reset values
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage : frame_pkg

// file: hdl/byte_sum.sv
// Running modulo-256 byte accumulator
`timescale 1ns/1ps
module byte_sum (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic add,
	input wire logic [7:0] din,
	// Result
	output logic [7:0] sum
);
	// Clear wins over add; 8-bit wrap is intended
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sum <= frame_pkg::BYTE_ZERO;
		end else if (clear) begin
			sum <= frame_pkg::BYTE_ZERO;
		end else if (add) begin
			sum <= sum + din;
		end
	end
endmodule : byte_sum

// file: hdl/pin_sync.sv
// Two-stage synchroniser for one level
`timescale 1ns/1ps
module pin_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Level
	input wire logic din,
	output logic dout
);
	logic meta_r;
	// First stage feeds only the second
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : pin_sync

// file: hdl/motion_command_frame_handler.sv
// Command frame assembler, executor handoff and reply builder
// Summary of operation
// [R1] Core is cmd, type, bank, four-byte value
// [R2] Serial frame: address, core, checksum
// [R3] Value sent most significant byte first
// [R4] Command checksum sums preceding eight bytes
// [R5] Transmit only when answering a command
// [R6] One reply per command, after execution
// [R7] Host waits for reply before next command
// [R8] Reply: host addr, module addr, status, cmd, value
// [R9] Reply checksum sums all other bytes
// [R10] Status 100 done, 101 stored
// [R11] Error status codes one to six
// [R12] CAN command: no address, no checksum
// [R13] CAN reply: no address, no checksum
// [R14] Foreign address frames dropped, no reply
// [R15] Realign to address byte after frame
`timescale 1ns/1ps
module motion_command_frame_handler (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Configuration (static straps)
	input wire logic can_mode,
	input wire logic [7:0] module_addr,
	input wire logic [7:0] host_addr,
	// Receive byte stream from link
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	// Transmit byte stream to link
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// Link direction
	output logic tx_active,
	// Executor request
	output logic exec_req,
	output logic [7:0] exec_cmd,
	output logic [7:0] exec_type,
	output logic [7:0] exec_bank,
	output logic [31:0] exec_value,
	// Executor answer
	input wire logic exec_done,
	input wire logic [7:0] exec_status,
	input wire logic [31:0] exec_result,
	// Frame events
	output logic frame_drop
);
	typedef enum logic [2:0] {S_RECV, S_EXEC, S_WAIT, S_SEND} state_e;
	state_e state_r;
	logic [3:0] rx_cnt_r;
	logic [3:0] tx_cnt_r;
	logic [7:0] addr_r;
	logic [7:0] status_r;
	logic [31:0] result_r;
	logic bad_sum_r;
	logic can_r;
	logic [7:0] rx_sum;
	logic [7:0] tx_sum;
	logic [3:0] rx_last;
	logic rx_take;
	logic rx_end;
	logic tx_take;
	logic tx_end;
	logic [7:0] tx_byte_nxt;
	logic [3:0] tx_idx;
	logic [3:0] tx_last;
	logic can_pin;

	// Frame length per link variant
	assign rx_last = can_r ? frame_pkg::CAN_LAST : frame_pkg::SER_LAST; // R2 R12
	assign rx_take = rx_valid && (state_r == S_RECV);
	assign rx_end = rx_take && (rx_cnt_r == rx_last);
	assign tx_take = tx_valid && tx_ready;
	assign tx_last = can_r ? frame_pkg::CAN_TX_LAST : frame_pkg::SER_LAST; // R13
	assign tx_end = tx_take && (tx_cnt_r == tx_last);
	// CAN replies skip both address slots; a take loads the following byte
	assign tx_idx = (can_r ? frame_pkg::POS_TYPE : frame_pkg::CNT_ZERO) +
		(tx_take ? (tx_cnt_r + 4'h1) : tx_cnt_r);

	// Mode strap is a pin, so it passes two flip-flops first
	pin_sync u_can_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.din(can_mode),
		.dout(can_pin)
	);

	// Link mode held fixed from the first byte to the end of the reply
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			can_r <= 1'b0;
		end else if (state_r == S_RECV && rx_cnt_r == frame_pkg::CNT_ZERO && !rx_take) begin
			can_r <= can_pin;
		end
	end

	// Command checksum accumulator over received bytes
	byte_sum u_rx_sum (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(rx_end),
		.add(rx_take),
		.din(rx_data),
		.sum(rx_sum)
	);

	// Reply checksum accumulator over sent bytes
	byte_sum u_tx_sum (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(state_r != S_SEND),
		.add(tx_take),
		.din(tx_data),
		.sum(tx_sum)
	);

	// Receive byte counter, realigns after each frame
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_cnt_r <= frame_pkg::CNT_ZERO; // R15
		end else if (rx_end) begin
			rx_cnt_r <= frame_pkg::CNT_ZERO; // R15
		end else if (rx_take) begin
			rx_cnt_r <= rx_cnt_r + 4'h1;
		end
	end

	// Field capture; value shifted in MSB first
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addr_r <= frame_pkg::BYTE_ZERO;
			exec_cmd <= frame_pkg::BYTE_ZERO;
			exec_type <= frame_pkg::BYTE_ZERO;
			exec_bank <= frame_pkg::BYTE_ZERO;
			exec_value <= frame_pkg::WORD_ZERO;
		end else if (rx_take) begin
			case (can_r ? (rx_cnt_r + 4'h1) : rx_cnt_r) // R1 R12
				frame_pkg::POS_ADDR: addr_r <= rx_data;
				frame_pkg::POS_CMD: exec_cmd <= rx_data;
				frame_pkg::POS_TYPE: exec_type <= rx_data;
				frame_pkg::POS_BANK: exec_bank <= rx_data;
				default: begin
					if (rx_cnt_r + (can_r ? 4'h1 : 4'h0) <= frame_pkg::POS_VAL3) begin
						exec_value <= {exec_value[23:0], rx_data}; // R3
					end
				end
			endcase
		end
	end

	// Checksum verdict at frame end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bad_sum_r <= 1'b0;
		end else if (rx_end) begin
			bad_sum_r <= !can_r && (rx_sum != rx_data); // R4
		end
	end

	// Drop pulse for foreign address frames
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			frame_drop <= 1'b0;
		end else begin
			frame_drop <= rx_end && !can_r && (addr_r != module_addr); // R14
		end
	end

	// Main sequence: receive, execute, send
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= S_RECV;
		end else begin
			case (state_r)
				S_RECV: begin
					if (rx_end) begin
						if (can_r || addr_r == module_addr) begin
							state_r <= S_EXEC;
						end // R14
					end
				end
				S_EXEC: begin
					state_r <= bad_sum_r ? S_SEND : S_WAIT; // R11
				end
				S_WAIT: begin
					if (exec_done) begin
						state_r <= S_SEND; // R6
					end
				end
				S_SEND: begin
					if (tx_end) begin
						state_r <= S_RECV; // R6 R15
					end
				end
				default: state_r <= S_RECV;
			endcase
		end
	end

	// Executor request pulse, only for good frames
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			exec_req <= 1'b0;
		end else begin
			exec_req <= (state_r == S_EXEC) && !bad_sum_r;
		end
	end

	// Status and result latched for the reply
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			status_r <= frame_pkg::BYTE_ZERO;
			result_r <= frame_pkg::WORD_ZERO;
		end else if (state_r == S_EXEC && bad_sum_r) begin
			status_r <= frame_pkg::ST_BAD_SUM; // R11
			result_r <= frame_pkg::WORD_ZERO;
		end else if (state_r == S_WAIT && exec_done) begin
			status_r <= exec_status; // R10 R11
			result_r <= exec_result;
		end
	end

	// Reply byte selection by position; CAN starts at the status slot
	always_comb begin
		case (tx_idx) // R8 R13
			frame_pkg::POS_ADDR: tx_byte_nxt = host_addr;
			frame_pkg::POS_CMD: tx_byte_nxt = module_addr;
			frame_pkg::POS_TYPE: tx_byte_nxt = status_r;
			frame_pkg::POS_BANK: tx_byte_nxt = exec_cmd;
			frame_pkg::POS_VAL0: tx_byte_nxt = result_r[31:24]; // R3
			frame_pkg::POS_VAL1: tx_byte_nxt = result_r[23:16];
			frame_pkg::POS_VAL2: tx_byte_nxt = result_r[15:8];
			frame_pkg::POS_VAL3: tx_byte_nxt = result_r[7:0];
			default: tx_byte_nxt = tx_sum + tx_data; // R9
		endcase
	end

	// Transmit stream; silent outside replies
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_valid <= 1'b0;
			tx_data <= frame_pkg::BYTE_ZERO;
			tx_cnt_r <= frame_pkg::CNT_ZERO;
			tx_active <= 1'b0;
		end else if (state_r == S_SEND) begin
			tx_active <= 1'b1; // R5
			if (!tx_valid || tx_take) begin
				tx_valid <= !tx_end;
				tx_data <= tx_byte_nxt;
			end
			if (tx_take) begin
				tx_cnt_r <= tx_end ? frame_pkg::CNT_ZERO : tx_cnt_r + 4'h1;
			end
		end else begin
			tx_valid <= 1'b0; // R5
			tx_active <= 1'b0;
			tx_cnt_r <= frame_pkg::CNT_ZERO;
		end
	end

	// Transmission only follows an accepted command
	a_tx_quiet: assert property (@(posedge sys_clk) disable iff (rst) // R5
		tx_valid |-> state_r == S_SEND) else $error("transmit outside reply");
	a_req_once: assert property (@(posedge sys_clk) disable iff (rst) // R6
		exec_req |=> !exec_req) else $error("double executor request");
	a_drop_nosend: assert property (@(posedge sys_clk) disable iff (rst) // R14
		frame_drop |-> state_r == S_RECV) else $error("dropped frame answered");
	a_can_len: assert property (@(posedge sys_clk) disable iff (rst) // R12
		(rx_end && can_r) |=> state_r == S_EXEC) else $error("can frame not taken");
	a_realign: assert property (@(posedge sys_clk) disable iff (rst) // R15
		rx_end |=> rx_cnt_r == frame_pkg::CNT_ZERO) else $error("no realign");
	a_sum_err: assert property (@(posedge sys_clk) disable iff (rst) // R11
		(state_r == S_EXEC && bad_sum_r) |=> status_r == frame_pkg::ST_BAD_SUM)
		else $error("bad sum status");
	a_first_addr: assert property (@(posedge sys_clk) disable iff (rst) // R8
		(state_r == S_SEND && !can_r && $rose(tx_valid)) |-> tx_data == host_addr)
		else $error("reply address");
	a_sum_check: assert property (@(posedge sys_clk) disable iff (rst) // R4
		(rx_end && !can_r) |=> bad_sum_r == ($past(rx_sum) != $past(rx_data)))
		else $error("checksum verdict");

	// Reply walk: executor answer, one load cycle, then first byte offered
	sequence s_exec_answer;
		state_r == S_WAIT && exec_done;
	endsequence
	sequence s_reply_open;
		state_r == S_SEND ##1 (tx_valid && tx_active);
	endsequence
	a_reply_after: assert property (@(posedge sys_clk) disable iff (rst) // R6
		s_exec_answer |=> s_reply_open) else $error("reply not opened");
	a_can_first: assert property (@(posedge sys_clk) disable iff (rst) // R13
		(state_r == S_SEND && can_r && $rose(tx_valid)) |-> tx_data == status_r)
		else $error("can reply head");
	// Checksum byte must equal the sum of the eight bytes already taken
	a_reply_sum: assert property (@(posedge sys_clk) disable iff (rst) // R9
		(tx_valid && !can_r && tx_cnt_r == frame_pkg::SER_LAST) |-> tx_data == tx_sum)
		else $error("reply checksum");
	a_status_pass: assert property (@(posedge sys_clk) disable iff (rst) // R10
		(state_r == S_WAIT && exec_done) |=> status_r == $past(exec_status))
		else $error("status not kept");
	a_tx_active: assert property (@(posedge sys_clk) disable iff (rst) // R5
		tx_valid |-> tx_active) else $error("direction not set");
endmodule : motion_command_frame_handler

// file: bench/host_model.sv
// Host side model: sends command bytes, collects reply bytes
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic sys_clk,
	// Command byte stream
	output logic rx_valid,
	output logic [7:0] rx_data,
	// Reply byte stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// One byte per cycle, line shows inverse data once released
	task automatic send(input logic [71:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			rx_valid <= 1'b1;
			rx_data <= f[71 - 8 * i -: 8];
		end
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		rx_data <= ~rx_data;
	endtask : send
	// Whole reply taken before the next command goes out
	task automatic recv(input int n, input int slow, output logic [71:0] r, output int cnt);
		r = '0;
		cnt = 0;
		for (int c = 0; c < (n > 0 ? 400 : 60); c++) begin
			@(posedge sys_clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				r = {r[63:0], tx_data};
				cnt++;
			end
			if (n > 0 && cnt == n) break;
			tx_ready <= (slow == 0) || (c % 3 == 2);
		end
		tx_ready <= 1'b0;
	endtask : recv
endmodule : host_model

// file: bench/testbench.sv
// Self-checking bench for the command frame handler
`timescale 1ns/1ps
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic can_mode = 1'b0;
	logic [7:0] module_addr = 8'h05;
	logic [7:0] host_addr = 8'h02;
	logic rx_valid, tx_valid, tx_ready, tx_active, exec_req, frame_drop;
	logic [7:0] rx_data, tx_data, exec_cmd, exec_type, exec_bank;
	logic [31:0] exec_value;
	logic exec_done = 1'b0;
	logic [7:0] exec_status = 8'h00;
	logic [31:0] exec_result = 32'h0000_0000;
	logic [7:0] ex_st;
	logic [31:0] ex_res;
	logic [55:0] seen_f;
	int err_count = 0, checked = 0, reqs = 0, drops = 0, wait_c = 0, bad_act = 0;
	// Clock
	always #25 sys_clk = ~sys_clk;
	motion_command_frame_handler motion_command_frame_handler_inst (
		.sys_clk(sys_clk), .rst(rst), .can_mode(can_mode), .module_addr(module_addr),
		.host_addr(host_addr), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .tx_active(tx_active),
		.exec_req(exec_req), .exec_cmd(exec_cmd), .exec_type(exec_type),
		.exec_bank(exec_bank), .exec_value(exec_value), .exec_done(exec_done),
		.exec_status(exec_status), .exec_result(exec_result), .frame_drop(frame_drop));
	host_model host_model_inst (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
	// Executor stand-in: answers each request after three cycles
	always @(posedge sys_clk) begin
		exec_done <= 1'b0;
		if (frame_drop === 1'b1) drops++;
		if (tx_valid === 1'b1 && tx_active !== 1'b1) bad_act++;
		if (exec_req === 1'b1) begin
			reqs++;
			seen_f = {exec_cmd, exec_type, exec_bank, exec_value};
			wait_c = 3;
		end else if (wait_c > 0) begin
			wait_c--;
			if (wait_c == 0) begin
				exec_done <= 1'b1;
				exec_status <= ex_st;
				exec_result <= ex_res;
			end
		end
	end
	function automatic logic [7:0] bsum(input logic [71:0] f);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 1; i < 9; i++) s = s + f[i * 8 +: 8];
		return s;
	endfunction : bsum
	task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// One command out, then n reply bytes back (none when n is zero)
	task automatic do_cmd(input logic can, input logic [7:0] adr, input logic [55:0] core,
		input logic [7:0] bias, input int slow, input int n, output logic [71:0] r);
		logic [71:0] f;
		int cnt;
		f = {adr, core, 8'h00};
		f[7:0] = bsum(f) + bias;
		if (can) f = {core, 16'h0000};
		@(posedge sys_clk);
		can_mode <= can;
		// Mode strap passes a two-stage synchroniser before the frame starts
		repeat (3) @(posedge sys_clk);
		host_model_inst.send(f, can ? 7 : 9);
		host_model_inst.recv(n, slow, r, cnt);
		chk("reply count", 72'(cnt), 72'(n));
		if (n > 0 && cnt != n) test_done();
	endtask : do_cmd
	task automatic s_serial_ok();
		logic [71:0] r, e;
		int q;
		q = reqs;
		ex_st = frame_pkg::ST_OK;
		ex_res = 32'hfedc_0a01;
		do_cmd(1'b0, 8'h05, 56'h04_00_01_8001_00ff, 8'h00, 1, 9, r);
		chk("exec count", 72'(reqs - q), 72'h1);
		chk("exec fields", 72'(seen_f), 72'h04_00_01_8001_00ff);
		e = {8'h02, 8'h05, frame_pkg::ST_OK, 8'h04, 32'hfedc_0a01, 8'h00};
		e[7:0] = bsum(e);
		chk("serial reply", r, e);
		chk("reply active", 72'(bad_act), 72'h0);
	endtask : s_serial_ok
	task automatic s_can_codes();
		logic [71:0] r;
		logic [7:0] codes [6] = '{8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
		for (int i = 0; i < 6; i++) begin
			ex_st = codes[i];
			ex_res = {codes[i], 24'h80_0001};
			do_cmd(1'b1, 8'h00, {codes[i], 48'h11_22_3344_5566}, 8'h00, 0, 6, r);
			chk("can exec", 72'(seen_f), {16'h0000, codes[i], 48'h11_22_3344_5566});
			chk("can reply", r, 72'({codes[i], codes[i], codes[i], 24'h80_0001}));
		end
	endtask : s_can_codes
	task automatic s_bad_sum();
		logic [71:0] r;
		int q;
		q = reqs;
		do_cmd(1'b0, 8'h05, 56'h07_01_00_0000_0009, 8'h01, 0, 9, r);
		chk("bad sum exec", 72'(reqs - q), 72'h0);
		chk("bad sum head", 72'(r[71:40]), 72'h02_05_01_07);
		chk("bad sum csum", 72'(r[7:0]), 72'(bsum(r)));
	endtask : s_bad_sum
	task automatic s_foreign();
		logic [71:0] r;
		int q, d;
		q = reqs;
		d = drops;
		do_cmd(1'b0, 8'h06, 56'h04_00_01_0000_0001, 8'h00, 0, 0, r);
		chk("drop pulse", 72'(drops - d), 72'h1);
		chk("drop exec", 72'(reqs - q), 72'h0);
		chk("idle link", 72'(tx_active), 72'h0);
	endtask : s_foreign
	task automatic test_done();
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		s_serial_ok();
		s_can_codes();
		s_bad_sum();
		s_foreign();
		s_serial_ok();
		test_done();
	end
endmodule : testbench
